// ### core/memory_and_link_error_status.sv
`timescale 1ns/100ps
module memory_and_link_error_status
   import err_status_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              rst_b_i,
   input  wire logic              spi_mode_i,
   input  wire logic              reg_rd_i,
   input  wire logic              reg_wr_i,
   input  wire logic [7:0]        reg_addr_i,
   input  wire logic [7:0]        reg_wdata_i,
   input  wire logic              frame_mem_err_sent_i,
   input  wire logic              frame_link_err_sent_i,
   input  wire logic              factory_otp_fault_i,
   input  wire logic              user_otp_fault_i,
   input  wire logic              otp_write_busy_i,
   input  wire logic              temperature_range_fault_i,
   input  wire logic              miso_readback_mismatch_i,
   input  wire logic [CODE_W-1:0] user_reg_code_i,
   output logic      [7:0]        reg_rdata_o,
   output logic                   init_complete_lock_o,
   output logic                   user_write_allowed_o,
   output logic                   memory_temperature_summary_flag_o,
   output logic                   communication_summary_flag_o
);
   logic rst_meta_reg;
   logic rst_sync_b;
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_meta_reg <= 1'b0;
         rst_sync_b   <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_b   <= rst_meta_reg;
      end
   end

   wire rd_mem   = reg_rd_i && (reg_addr_i == MEM_STATUS_ADDR);
   wire rd_link  = reg_rd_i && (reg_addr_i == LINK_STATUS_ADDR);
   wire rd_lock  = reg_rd_i && (reg_addr_i == LOCK_ADDR);
   wire wr_lock  = reg_wr_i && (reg_addr_i == LOCK_ADDR);
   wire clr_mem  = rd_mem || frame_mem_err_sent_i;
   wire clr_link = rd_link || (spi_mode_i && frame_link_err_sent_i);

   logic lock_reg;
   always_ff @(posedge clk_i or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         lock_reg <= 1'b0;
      end else if (wr_lock && reg_wdata_i[LOCK_BIT]) begin
         lock_reg <= 1'b1;
      end
   end

   // reference code captured when the lock closes, then compared every cycle
   logic              lock_d_reg;
   logic [CODE_W-1:0] ref_code_reg;
   always_ff @(posedge clk_i or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         lock_d_reg   <= 1'b0;
         ref_code_reg <= CODE_RESET;
      end else begin
         lock_d_reg <= lock_reg;
         if (lock_reg && !lock_d_reg) begin
            ref_code_reg <= user_reg_code_i;
         end
      end
   end
   wire code_mismatch = lock_reg && lock_d_reg && (user_reg_code_i != ref_code_reg);

   logic [4:0] set_vec;
   logic [4:0] flag_vec;
   assign set_vec = {factory_otp_fault_i, user_otp_fault_i, code_mismatch,
                     temperature_range_fault_i, spi_mode_i && miso_readback_mismatch_i};
   genvar g;
   generate
      for (g = 0; g < 5; g++) begin : g_flag
         sticky_flag u_flag (
            .clk_i  (clk_i),
            .rst_b_i(rst_sync_b),
            .set_i  (set_vec[g]),
            .clr_i  ((g == 0) ? clr_link : clr_mem),
            .flag_o (flag_vec[g])
         );
      end
   endgenerate
   wire fotp = flag_vec[4];
   wire uotp = flag_vec[3];
   wire urw  = flag_vec[2];
   wire temp = flag_vec[1];
   wire miso = flag_vec[0];

   logic busy_reg;
   always_ff @(posedge clk_i or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         busy_reg <= 1'b0;
      end else begin
         busy_reg <= otp_write_busy_i;
      end
   end

   logic [7:0] mem_word;
   logic [7:0] link_word;
   always_comb begin
      mem_word            = STATUS_RESET;
      mem_word[FOTP_BIT]  = fotp;
      mem_word[UOTP_BIT]  = uotp;
      mem_word[URW_BIT]   = urw;
      mem_word[WBUSY_BIT] = busy_reg;
      mem_word[TEMP_BIT]  = temp;
      link_word           = STATUS_RESET;
      link_word[MISO_BIT] = miso;
   end

   logic [7:0] rdata_next;
   assign rdata_next = rd_mem  ? mem_word :
                       rd_link ? link_word :
                       rd_lock ? {lock_reg, 7'h00} : STATUS_RESET;
   always_ff @(posedge clk_i or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         reg_rdata_o <= STATUS_RESET;
      end else if (reg_rd_i) begin
         reg_rdata_o <= rdata_next;
      end
   end

   assign init_complete_lock_o = lock_reg;
   assign user_write_allowed_o = !lock_reg;
   assign memory_temperature_summary_flag_o = fotp | uotp | urw | busy_reg | temp;
   assign communication_summary_flag_o = miso;

   property p_fotp_set;
      @(posedge clk_i) disable iff (!rst_sync_b)
      factory_otp_fault_i |=> fotp;
   endproperty
   a_fotp_set: assert property (p_fotp_set) else $error("factory fault not flagged");
   property p_uotp_set;
      @(posedge clk_i) disable iff (!rst_sync_b)
      user_otp_fault_i |=> mem_word[UOTP_BIT];
   endproperty
   a_uotp_set: assert property (p_uotp_set) else $error("user otp fault not flagged");
   property p_urw;
      @(posedge clk_i) disable iff (!rst_sync_b)
      (!lock_reg && !clr_mem) |=> (urw == $past(urw));
   endproperty
   a_urw: assert property (p_urw) else $error("integrity flag moved while unlocked");
   property p_busy;
      @(posedge clk_i) disable iff (!rst_sync_b)
      otp_write_busy_i |=> mem_word[WBUSY_BIT] ##1 ($past(otp_write_busy_i) == busy_reg);
   endproperty
   a_busy: assert property (p_busy) else $error("busy flag does not follow write");
   property p_temp;
      @(posedge clk_i) disable iff (!rst_sync_b)
      temperature_range_fault_i |=> mem_word[TEMP_BIT];
   endproperty
   a_temp: assert property (p_temp) else $error("temperature fault not flagged");
   property p_clr_mem;
      @(posedge clk_i) disable iff (!rst_sync_b)
      (rd_mem && !factory_otp_fault_i) |=> !fotp;
   endproperty
   a_clr_mem: assert property (p_clr_mem) else $error("memory read did not clear");
   property p_miso;
      @(posedge clk_i) disable iff (!rst_sync_b)
      (spi_mode_i && miso_readback_mismatch_i) |=> link_word[MISO_BIT];
   endproperty
   a_miso: assert property (p_miso) else $error("mismatch not flagged");
   property p_clr_link;
      @(posedge clk_i) disable iff (!rst_sync_b)
      (rd_link && !miso_readback_mismatch_i) |=> !miso;
   endproperty
   a_clr_link: assert property (p_clr_link) else $error("link read did not clear");
   property p_sum;
      @(posedge clk_i) disable iff (!rst_sync_b)
      memory_temperature_summary_flag_o == (mem_word != STATUS_RESET);
   endproperty
   a_sum: assert property (p_sum) else $error("summary flag wrong");
   property p_comm;
      @(posedge clk_i) disable iff (!rst_sync_b)
      communication_summary_flag_o == link_word[MISO_BIT];
   endproperty
   a_comm: assert property (p_comm) else $error("comm summary wrong");
   property p_lock;
      @(posedge clk_i) disable iff (!rst_sync_b)
      lock_reg |=> lock_reg && !user_write_allowed_o;
   endproperty
   a_lock: assert property (p_lock) else $error("lock dropped");
   property p_rsv;
      @(posedge clk_i) disable iff (!rst_sync_b)
      rd_link |=> (reg_rdata_o[6:0] == 7'h00);
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits nonzero");
   // reserved memory bits, so a stray field can not leak into bits 3, 1 or 0
   property p_rsv_mem;
      @(posedge clk_i) disable iff (!rst_sync_b)
      rd_mem |=> (reg_rdata_o[3] == 1'b0) && (reg_rdata_o[1:0] == 2'b00);
   endproperty
   a_rsv_mem: assert property (p_rsv_mem) else $error("reserved memory bits nonzero");
   property p_lock_read;
      @(posedge clk_i) disable iff (!rst_sync_b)
      rd_lock |=> (reg_rdata_o[LOCK_BIT] == $past(lock_reg)) && (reg_rdata_o[6:0] == 7'h00);
   endproperty
   a_lock_read: assert property (p_lock_read) else $error("lock readback wrong");
   property p_urw_set;
      @(posedge clk_i) disable iff (!rst_sync_b)
      code_mismatch |=> urw;
   endproperty
   a_urw_set: assert property (p_urw_set) else $error("integrity mismatch not flagged");
   property p_clr_frame;
      @(posedge clk_i) disable iff (!rst_sync_b)
      (frame_mem_err_sent_i && !user_otp_fault_i) |=> !uotp;
   endproperty
   a_clr_frame: assert property (p_clr_frame) else $error("frame did not clear");
   // outside spi mode a status frame must not wipe the link flag
   property p_link_keep;
      @(posedge clk_i) disable iff (!rst_sync_b)
      (miso && !spi_mode_i && !rd_link) |=> miso;
   endproperty
   a_link_keep: assert property (p_link_keep) else $error("link flag lost");
   c_mem_clear: cover property (@(posedge clk_i) fotp ##1 rd_mem ##1 !fotp);
   c_lock: cover property (@(posedge clk_i) !lock_reg ##1 lock_reg);
   c_urw: cover property (@(posedge clk_i) code_mismatch ##1 urw);
   c_set_wins: cover property (@(posedge clk_i) (factory_otp_fault_i && clr_mem) ##1 fotp);
   c_link_clear: cover property (@(posedge clk_i) miso ##1 clr_link ##1 !miso);
endmodule : memory_and_link_error_status

// ### core/err_status_pkg.sv
package err_status_pkg;
   localparam logic [7:0] MEM_STATUS_ADDR   = 8'h03;
   localparam logic [7:0] LINK_STATUS_ADDR  = 8'h04;
   localparam logic [7:0] LOCK_ADDR         = 8'h10;
   localparam int         FOTP_BIT          = 7;
   localparam int         UOTP_BIT          = 6;
   localparam int         URW_BIT           = 5;
   localparam int         WBUSY_BIT         = 4;
   localparam int         TEMP_BIT          = 2;
   localparam int         MISO_BIT          = 7;
   localparam int         LOCK_BIT          = 7;
   localparam int         CODE_W            = 8;
   localparam logic [7:0] STATUS_RESET      = 8'h00;
   localparam logic [CODE_W-1:0] CODE_RESET = 8'h00;
endpackage : err_status_pkg

// ### core/sticky_flag.sv
`timescale 1ns/100ps
module sticky_flag (
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   input  wire logic set_i,
   input  wire logic clr_i,
   output logic      flag_o
);
   // set wins over a clear in the same cycle
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         flag_o <= 1'b0;
      end else if (set_i) begin
         flag_o <= 1'b1;
      end else if (clr_i) begin
         flag_o <= 1'b0;
      end
   end
endmodule : sticky_flag

// ### bench/host_model.sv
`timescale 1ns/100ps
module host_model (
   input  wire logic       clk_i,
   output logic            rd_o,
   output logic            wr_o,
   output logic [7:0]      addr_o,
   output logic [7:0]      wdata_o
);
   initial begin
      rd_o = 1'b0;
      wr_o = 1'b0;
      addr_o = 8'h00;
      wdata_o = 8'h00;
   end
   // one-cycle strobe; a lock write is just a write to 10h
   task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      rd_o = ~w;
      wr_o = w;
      addr_o = a;
      wdata_o = d;
      @(negedge clk_i);
      rd_o = 1'b0;
      wr_o = 1'b0;
      // released bus shows no stale value
      addr_o = ~a;
      wdata_o = ~d;
   endtask : access
endmodule : host_model

// ### bench/memory_and_link_error_status_bench.sv
`timescale 1ns/100ps
module memory_and_link_error_status_bench;
   logic       clk;
   logic       rst_b;
   logic       spi;
   logic       busy;
   logic [5:0] f;
   logic [7:0] code;
   logic       rd;
   logic       wr;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic       lock;
   logic       allow;
   logic       msum;
   logic       csum;
   int         bad_count;
   int         n_tests;
   wire  [7:0] st = {4'h0, lock, allow, msum, csum};
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   host_model host (.clk_i(clk), .rd_o(rd), .wr_o(wr), .addr_o(addr), .wdata_o(wdata));
   memory_and_link_error_status DUT (
      .clk_i(clk), .rst_b_i(rst_b), .spi_mode_i(spi), .reg_rd_i(rd), .reg_wr_i(wr),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .frame_mem_err_sent_i(f[1]),
      .frame_link_err_sent_i(f[0]), .factory_otp_fault_i(f[5]), .user_otp_fault_i(f[4]),
      .otp_write_busy_i(busy), .temperature_range_fault_i(f[3]),
      .miso_readback_mismatch_i(f[2]), .user_reg_code_i(code), .reg_rdata_o(rdata),
      .init_complete_lock_o(lock), .user_write_allowed_o(allow),
      .memory_temperature_summary_flag_o(msum), .communication_summary_flag_o(csum));
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // waits one more edge so either answer latency reads the same
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      host.access(1'b0, a, 8'h00);
      @(negedge clk);
      chk("rdata", e, rdata);
   endtask : rdc
   task automatic pulse(input logic [5:0] m);
      @(negedge clk);
      f = m;
      @(negedge clk);
      f = 6'h00;
   endtask : pulse
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : wrap_up
   initial begin
      {spi, busy, f, rst_b, bad_count, n_tests} = '0;
      code = 8'h5a;
      repeat (20) @(negedge clk);
      rst_b = 1'b1;
      repeat (3) @(negedge clk);
      chk("status", 8'h04, st);
      rdc(8'h04, 8'h00);
      pulse(6'h38);
      chk("status", 8'h06, st);
      rdc(8'h03, 8'hc4);
      rdc(8'h03, 8'h00);
      pulse(6'h38);
      pulse(6'h02);
      rdc(8'h03, 8'h00);
      pulse(6'h22);
      rdc(8'h03, 8'h80);
      busy = 1'b1;
      rdc(8'h03, 8'h10);
      chk("status", 8'h06, st);
      busy = 1'b0;
      repeat (2) @(negedge clk);
      chk("status", 8'h04, st);
      spi = 1'b1;
      pulse(6'h04);
      chk("status", 8'h05, st);
      rdc(8'h04, 8'h80);
      rdc(8'h04, 8'h00);
      pulse(6'h04);
      spi = 1'b0;
      pulse(6'h01);
      chk("status", 8'h05, st);
      spi = 1'b1;
      pulse(6'h01);
      chk("status", 8'h04, st);
      spi = 1'b0;
      pulse(6'h04);
      chk("status", 8'h04, st);
      host.access(1'b1, 8'h03, 8'hff);
      rdc(8'h03, 8'h00);
      rdc(8'h05, 8'h00);
      code = 8'h5b;
      rdc(8'h03, 8'h00);
      host.access(1'b1, 8'h10, 8'h80);
      chk("status", 8'h08, st);
      rdc(8'h10, 8'h80);
      rdc(8'h03, 8'h00);
      host.access(1'b1, 8'h10, 8'h00);
      chk("status", 8'h08, st);
      code = 8'h3c;
      repeat (3) @(negedge clk);
      rdc(8'h03, 8'h20);
      rst_b = 1'b0;
      repeat (2) @(negedge clk);
      rst_b = 1'b1;
      repeat (3) @(negedge clk);
      chk("status", 8'h04, st);
      rdc(8'h10, 8'h00);
      wrap_up();
   end
endmodule : memory_and_link_error_status_bench
